// *** hdl/ncr_map.svh ***
`ifndef NCR_MAP_SVH
`define NCR_MAP_SVH
// ---------------------------------------------------------------
// Register numbers
// ---------------------------------------------------------------
`define NCR_REG_IDENT      8'h00
`define NCR_REG_SWDESC     8'h01
`define NCR_REG_SWCFG      8'h04
`define NCR_REG_NODEID     8'h05
`define NCR_REG_PLL        8'h06
`define NCR_REG_SWCLK      8'h07
`define NCR_REG_REFCLK     8'h08
`define NCR_REG_SCANID     8'h09
`define NCR_REG_USER       8'h0A
`define NCR_REG_DIRLO      8'h0C
`define NCR_REG_DIRHI      8'h0D
`define NCR_REG_SPARE      8'h10
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define NCR_CFG_LOCK_ALL   31
`define NCR_CFG_LOCK_PLL   8
`define NCR_CFG_HDR1       0
`define NCR_PLL_NORST      31
`define NCR_PLL_NOWAIT     30
`define NCR_PLL_BYPASS     29
`define NCR_PLL_JTAGBOOT   28
`define NCR_PLL_MASK       32'hF39F_FF7F
`define NCR_CFG_MASK       32'h8000_0101
`define NCR_HALF_MASK      32'h0000_FFFF
`define NCR_SPARE_MASK     32'h0000_0003
// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define NCR_CFG_RST        32'h0000_0000
`define NCR_NODEID_RST     16'h0000
`define NCR_PLL_RST        32'h0000_0000
`define NCR_SWCLK_RST      16'h0000
`define NCR_REFCLK_RST     16'h0003
`define NCR_DIR_RST        32'h0000_0000
`define NCR_SPARE_RST      2'h0
`endif

// *** hdl/ncr_node_regs.sv ***
// Functional notes
// - registers reached only by config read/write, register number decoded
// - identification bits 23:16 hold boot pins caught at power-on
// - switch description gives link and processor counts, read-only
// - lock bit 31 refuses writes to all switch control registers
// - bit 8 blocks writes to PLL settings register
// - config bit 0 selects one-byte headers, resets to zero
// - node identifier is writable 16 bits, reset zero
// - PLL write resets the tile unless suppressed
// - PLL write with bit 31 set applies without chip reset
// - PLL write bit 30 skips waiting for re-lock
// - PLL bit 29 bypasses the PLL
// - PLL bit 28 forces boot over the scan port
// - output divider bits 25:23 hold ratio minus one
// - feedback multiplier bits 20:8 hold ratio minus one
// - input divider bits 6:0 hold ratio minus one
// - switch clock divider bits 15:0 writable, reset zero
// - reference clock divider bits 15:0 writable, reset three
// - user code bits 31:18 from OTP, 17:0 metal ID
// - route by direction of most significant mismatching bit
// - low direction register, nibble k for dimension k
// - high direction register for dimensions 8 to 15
`timescale 1ns/1ps
`default_nettype none
`include "ncr_map.svh"
module ncr_node_regs
    import ncr_pkg::*;
#(
    parameter logic [7:0]  SW_VERSION   = 8'h01,
    parameter logic [7:0]  SW_REVISION  = 8'h00,
    parameter logic [7:0]  NUM_LINKS    = 8'h08,
    parameter logic [7:0]  NUM_SW_PROCS = 8'h02,
    parameter logic [7:0]  NUM_DEV_PROCS = 8'h02,
    // Arbitrary identification value
    parameter logic [31:0] SCAN_ID      = 32'h0000_1001
)
(
    input  wire logic        ref_clk_in,
    input  wire logic        resetn_in,
    input  wire logic        cfg_valid_in,
    input  wire logic        cfg_write_in,
    input  wire logic [7:0]  cfg_regnum_in,
    input  wire logic [31:0] cfg_wdata_in,
    output logic             cfg_ack_out,
    output logic [31:0]      cfg_rdata_out,
    input  wire logic [7:0]  boot_select_pins_in,
    input  wire logic [13:0] otp_user_code_in,
    input  wire logic [17:0] metal_id_in,
    output logic             header_one_byte_out,
    output logic [15:0]      node_id_out,
    output logic             tile_reset_out,
    output logic             pll_relock_wait_out,
    output logic             pll_bypass_out,
    output logic             boot_from_jtag_out,
    output logic [2:0]       pll_out_div_out,
    output logic [12:0]      pll_fb_mult_out,
    output logic [6:0]       pll_in_div_out,
    output logic [15:0]      switch_clk_div_out,
    output logic [15:0]      ref_clk_div_out,
    output logic [1:0]       spare_bits_out,
    input  wire logic        route_req_in,
    input  wire logic [15:0] route_dest_in,
    output logic             route_valid_out,
    output logic             route_local_out,
    output ncr_dir_t         route_dir_out
);
    // ---------------------------------------------------------------
    // Decode helper
    // ---------------------------------------------------------------
    function automatic logic hit(input logic [7:0] num,
                                 input logic [7:0] off);
        hit = (num == off);
    endfunction : hit

    logic        rst_meta_r;
    logic        rst_n_r;
    logic [7:0]  boot_s1_r, boot_s2_r, boot_s3_r;
    logic [2:0]  boot_fill_r;
    logic [7:0]  boot_cap_r;
    logic        boot_done_r;
    logic [31:0] cfg_r;
    logic [15:0] node_id_r;
    logic [31:0] pll_r;
    logic [15:0] swclk_r;
    logic [15:0] refclk_r;
    logic [31:0] dir_lo_r;
    logic [31:0] dir_hi_r;
    logic [1:0]  spare_r;
    logic        tile_rst_r, relock_r;
    logic        ack_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    ncr_acc_t    acc;
    logic        wr_ok, pll_wr;

    // ---------------------------------------------------------------
    // Reset release
    // ---------------------------------------------------------------
    // Two stages so the release edge never lands mid-setup
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    // ---------------------------------------------------------------
    // Boot pin capture
    // ---------------------------------------------------------------
    // Pins are asynchronous; three stages, stable when 2 and 3 agree
    always_ff @(posedge ref_clk_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            boot_s1_r <= 8'h00;
            boot_s2_r <= 8'h00;
            boot_s3_r <= 8'h00;
            boot_fill_r <= 3'h0; // Stages hold reset zeros, not pins
        end
        else
        begin
            boot_s1_r <= boot_select_pins_in;
            boot_s2_r <= boot_s1_r;
            boot_s3_r <= boot_s2_r;
            boot_fill_r <= {boot_fill_r[1:0], 1'b1};
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            boot_cap_r  <= 8'h00;
            boot_done_r <= 1'b0;
        end
        else if (!boot_done_r && boot_fill_r[2] && boot_s2_r == boot_s3_r)
        begin
            boot_cap_r  <= boot_s3_r;
            boot_done_r <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // Transaction decode
    // ---------------------------------------------------------------
    // only config transactions reach the bank
    always_comb
    begin
        if (!cfg_valid_in)
            acc = NCR_ACC_NONE;
        else if (cfg_write_in)
            acc = NCR_ACC_WRITE;
        else
            acc = NCR_ACC_READ;
    end

    assign wr_ok  = (acc == NCR_ACC_WRITE) && !cfg_r[`NCR_CFG_LOCK_ALL];
    // PLL write blocked by its own lock
    assign pll_wr = wr_ok && hit(cfg_regnum_in, `NCR_REG_PLL)
                    && !cfg_r[`NCR_CFG_LOCK_PLL];

    // ---------------------------------------------------------------
    // Writable registers
    // ---------------------------------------------------------------
    // header mode and locks; reserved bits masked
    always_ff @(posedge ref_clk_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
            cfg_r <= `NCR_CFG_RST;
        else if (wr_ok && hit(cfg_regnum_in, `NCR_REG_SWCFG))
            cfg_r <= cfg_wdata_in & `NCR_CFG_MASK;
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
            node_id_r <= `NCR_NODEID_RST;
        else if (wr_ok && hit(cfg_regnum_in, `NCR_REG_NODEID))
            node_id_r <= cfg_wdata_in[15:0];
    end

    // fields stored as ratio minus one
    always_ff @(posedge ref_clk_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
            pll_r <= `NCR_PLL_RST;
        else if (pll_wr)
            pll_r <= cfg_wdata_in & `NCR_PLL_MASK;
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            swclk_r  <= `NCR_SWCLK_RST;
            refclk_r <= `NCR_REFCLK_RST;
        end
        else
        begin
            if (wr_ok && hit(cfg_regnum_in, `NCR_REG_SWCLK))
                swclk_r <= cfg_wdata_in[15:0];
            if (wr_ok && hit(cfg_regnum_in, `NCR_REG_REFCLK))
                refclk_r <= cfg_wdata_in[15:0];
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            dir_lo_r <= `NCR_DIR_RST;
            dir_hi_r <= `NCR_DIR_RST;
            spare_r  <= `NCR_SPARE_RST;
        end
        else
        begin
            if (wr_ok && hit(cfg_regnum_in, `NCR_REG_DIRLO))
                dir_lo_r <= cfg_wdata_in;
            if (wr_ok && hit(cfg_regnum_in, `NCR_REG_DIRHI))
                dir_hi_r <= cfg_wdata_in;
            if (wr_ok && hit(cfg_regnum_in, `NCR_REG_SPARE))
                spare_r <= cfg_wdata_in[1:0];
        end
    end

    // ---------------------------------------------------------------
    // PLL write side effects
    // ---------------------------------------------------------------
    // pulses unless suppressed or skipped
    always_ff @(posedge ref_clk_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            tile_rst_r <= 1'b0;
            relock_r   <= 1'b0;
        end
        else
        begin
            tile_rst_r <= pll_wr && !cfg_wdata_in[`NCR_PLL_NORST];
            relock_r   <= pll_wr && !cfg_wdata_in[`NCR_PLL_NOWAIT];
        end
    end

    // ---------------------------------------------------------------
    // Read mux and answer
    // ---------------------------------------------------------------
    // read-only words, reserved bits zero
    always_comb
    begin
        unique case (cfg_regnum_in)
            `NCR_REG_IDENT:  rdata_nxt = {8'h00, boot_cap_r,
                                          SW_REVISION, SW_VERSION};
            `NCR_REG_SWDESC: rdata_nxt = {8'h00, NUM_LINKS,
                                          NUM_SW_PROCS, NUM_DEV_PROCS};
            `NCR_REG_SWCFG:  rdata_nxt = cfg_r;
            `NCR_REG_NODEID: rdata_nxt = {16'h0000, node_id_r};
            `NCR_REG_PLL:    rdata_nxt = pll_r;
            `NCR_REG_SWCLK:  rdata_nxt = {16'h0000, swclk_r};
            `NCR_REG_REFCLK: rdata_nxt = {16'h0000, refclk_r};
            `NCR_REG_SCANID: rdata_nxt = SCAN_ID;
            `NCR_REG_USER:   rdata_nxt = {otp_user_code_in, metal_id_in};
            `NCR_REG_DIRLO:  rdata_nxt = dir_lo_r;
            `NCR_REG_DIRHI:  rdata_nxt = dir_hi_r;
            `NCR_REG_SPARE:  rdata_nxt = {30'h0000_0000, spare_r};
            default:         rdata_nxt = 32'h0000_0000;
        endcase
    end

    // every transaction answered one cycle later, no error
    always_ff @(posedge ref_clk_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end
        else
        begin
            ack_r <= cfg_valid_in;
            if (acc == NCR_ACC_READ)
                rdata_r <= rdata_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign cfg_ack_out         = ack_r;
    assign cfg_rdata_out       = rdata_r;
    assign header_one_byte_out = cfg_r[`NCR_CFG_HDR1];
    assign node_id_out         = node_id_r;
    assign tile_reset_out      = tile_rst_r;
    assign pll_relock_wait_out = relock_r;
    // bypass straight from the stored bit
    assign pll_bypass_out      = pll_r[`NCR_PLL_BYPASS];
    assign boot_from_jtag_out  = pll_r[`NCR_PLL_JTAGBOOT];
    assign pll_out_div_out     = pll_r[25:23];
    assign pll_fb_mult_out     = pll_r[20:8];
    assign pll_in_div_out      = pll_r[6:0];
    assign switch_clk_div_out  = swclk_r;
    assign ref_clk_div_out     = refclk_r;
    assign spare_bits_out      = spare_r;

    // Routing lookup on the live tables
    ncr_route u_route
    (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_r),
        .req_in     (route_req_in),
        .dest_in    (route_dest_in),
        .node_id_in (node_id_r),
        .dir_lo_in  (dir_lo_r),
        .dir_hi_in  (dir_hi_r),
        .valid_out  (route_valid_out),
        .local_out  (route_local_out),
        .dir_out    (route_dir_out)
    );

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_r);

    a_ack_timing: assert property (
        cfg_valid_in |=> cfg_ack_out)
        else $error("transaction not answered next cycle");
    a_ident_boot: assert property (
        cfg_valid_in && !cfg_write_in
        && cfg_regnum_in == `NCR_REG_IDENT
        |=> cfg_rdata_out[23:16] == boot_cap_r)
        else $error("boot pins missing from identification");
    a_lock_all: assert property (
        cfg_r[`NCR_CFG_LOCK_ALL] |=> $stable(node_id_r)
        && $stable(dir_lo_r) && $stable(cfg_r))
        else $error("write went through global lock");
    a_pll_lock: assert property (
        cfg_r[`NCR_CFG_LOCK_PLL] |=> $stable(pll_r))
        else $error("PLL settings changed while locked");
    a_tile_reset: assert property (
        pll_wr && !cfg_wdata_in[`NCR_PLL_NORST]
        |=> tile_reset_out ##1 (!tile_reset_out || $past(pll_wr)))
        else $error("PLL write failed to reset tile");
    a_no_reset: assert property (
        !(pll_wr && !cfg_wdata_in[`NCR_PLL_NORST])
        |=> !tile_reset_out)
        else $error("tile reset without cause");
    a_relock_skip: assert property (
        pll_wr && cfg_wdata_in[`NCR_PLL_NOWAIT] |=> !pll_relock_wait_out)
        else $error("relock wait despite skip bit");
    a_reserved_zero: assert property (
        cfg_valid_in && !cfg_write_in
        && cfg_regnum_in == `NCR_REG_SWCFG
        |=> cfg_rdata_out[30:9] == 22'h000000)
        else $error("reserved config bits not zero");

    c_lock_set: cover property (wr_ok && hit(cfg_regnum_in, `NCR_REG_SWCFG)
        && cfg_wdata_in[`NCR_CFG_LOCK_ALL]);
    c_pll_reset: cover property (tile_reset_out);
    c_pll_quiet: cover property (pll_wr && cfg_wdata_in[`NCR_PLL_NORST]);
endmodule : ncr_node_regs
`default_nettype wire

// *** hdl/ncr_pkg.sv ***
package ncr_pkg;
    // Decode result of a configuration transaction
    typedef enum logic [3:0]
    {
        NCR_ACC_NONE  = 4'h1,
        NCR_ACC_READ  = 4'h2,
        NCR_ACC_WRITE = 4'h4,
        NCR_ACC_BAD   = 4'h8
    } ncr_acc_t;
    typedef logic [3:0] ncr_dir_t;
endpackage : ncr_pkg

// *** hdl/ncr_route.sv ***
`timescale 1ns/1ps
`default_nettype none
module ncr_route
    import ncr_pkg::*;
(
    input  wire logic        ref_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        req_in,
    input  wire logic [15:0] dest_in,
    input  wire logic [15:0] node_id_in,
    input  wire logic [31:0] dir_lo_in,
    input  wire logic [31:0] dir_hi_in,
    output logic             valid_out,
    output logic             local_out,
    output ncr_dir_t         dir_out
);
    logic [15:0] diff;
    logic [3:0]  dim;
    logic [63:0] table_w;

    // ---------------------------------------------------------------
    // Most significant mismatching bit picks the dimension
    // ---------------------------------------------------------------
    assign diff    = dest_in ^ node_id_in;
    assign table_w = {dir_hi_in, dir_lo_in};
    always_comb
    begin
        dim = 4'h0;
        for (int i = 0; i < 16; i++)
        begin
            if (diff[i])
                dim = 4'(i);
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            valid_out <= 1'b0;
            local_out <= 1'b0;
            dir_out   <= 4'h0;
        end
        else
        begin
            valid_out <= req_in;
            local_out <= (diff == 16'h0000);
            dir_out   <= table_w[{dim, 2'b00} +: 4];
        end
    end

    a_route_dir: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in)
        req_in && diff[15] |=> dir_out == $past(dir_hi_in[31:28]))
        else $error("route direction wrong for dimension 15");
    c_route_local: cover property (@(posedge ref_clk_in)
        disable iff (!rst_n_in) valid_out && local_out);
endmodule : ncr_route
`default_nettype wire

// *** testbench/ncr_cfg_init.sv ***
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Configuration transaction initiator
// ---------------------------------------------------------------
module ncr_cfg_init
(
    input  wire logic        ref_clk_in,
    output logic             cfg_valid_out,
    output logic             cfg_write_out,
    output logic [7:0]       cfg_regnum_out,
    output logic [31:0]      cfg_wdata_out,
    input  wire logic        cfg_ack_in,
    input  wire logic [31:0] cfg_rdata_in
);
    // Idle bus at time zero
    initial
    begin
        cfg_valid_out  = 1'b0;
        cfg_write_out  = 1'b0;
        cfg_regnum_out = 8'h00;
        cfg_wdata_out  = 32'h0000_0000;
    end

    task automatic xfer(input logic wr, input logic [7:0] rn,
                        input logic [31:0] wd, output logic ack,
                        output logic [31:0] rd);
        @(posedge ref_clk_in);
        cfg_valid_out  <= 1'b1;
        cfg_write_out  <= wr;
        cfg_regnum_out <= rn;
        cfg_wdata_out  <= wd;
        @(posedge ref_clk_in);
        // Released lines flip so a stale value never looks right
        cfg_valid_out  <= 1'b0;
        cfg_write_out  <= ~wr;
        cfg_regnum_out <= ~rn;
        cfg_wdata_out  <= ~wd;
        #1;
        ack = cfg_ack_in;
        rd  = cfg_rdata_in;
    endtask : xfer
endmodule : ncr_cfg_init
`default_nettype wire

// *** testbench/node_config_register_bank_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ncr_map.svh"
module node_config_register_bank_bench
    import ncr_pkg::*;
;
    // Arbitrary identification values
    localparam logic [7:0]  VER  = 8'h01;
    localparam logic [7:0]  REV  = 8'h00;
    localparam logic [31:0] SCAN = 32'h0000_1001;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        valid, write, ack, rreq = 1'b0;
    logic [7:0]  regnum;
    logic [7:0]  pins = 8'hA5;
    logic [13:0] otp = 14'h2D1B;
    logic [17:0] metal = 18'h3_1C4E;
    logic [15:0] dest = 16'h0000;
    logic [31:0] wdata, rdata;
    logic        hdr1, trst, relock, byp, jtag, rvalid, rlocal;
    logic [2:0]  pdiv;
    logic [12:0] mult;
    logic [6:0]  idiv;
    logic [15:0] nid, swclk, refclk;
    logic [1:0]  spare;
    ncr_dir_t    rdir;
    int          n_errors = 0;
    int          cmp_count = 0;

    ncr_node_regs #(.SW_VERSION(VER), .SW_REVISION(REV),
        .NUM_LINKS(8'h08), .NUM_SW_PROCS(8'h02),
        .NUM_DEV_PROCS(8'h02), .SCAN_ID(SCAN)) dut
    (
        .ref_clk_in(clk), .resetn_in(resetn), .cfg_valid_in(valid),
        .cfg_write_in(write), .cfg_regnum_in(regnum),
        .cfg_wdata_in(wdata), .cfg_ack_out(ack), .cfg_rdata_out(rdata),
        .boot_select_pins_in(pins), .otp_user_code_in(otp),
        .metal_id_in(metal), .header_one_byte_out(hdr1),
        .node_id_out(nid), .tile_reset_out(trst),
        .pll_relock_wait_out(relock), .pll_bypass_out(byp),
        .boot_from_jtag_out(jtag), .pll_out_div_out(pdiv),
        .pll_fb_mult_out(mult), .pll_in_div_out(idiv),
        .switch_clk_div_out(swclk), .ref_clk_div_out(refclk),
        .spare_bits_out(spare), .route_req_in(rreq),
        .route_dest_in(dest), .route_valid_out(rvalid),
        .route_local_out(rlocal), .route_dir_out(rdir)
    );

    ncr_cfg_init host
    (
        .ref_clk_in(clk), .cfg_valid_out(valid), .cfg_write_out(write),
        .cfg_regnum_out(regnum), .cfg_wdata_out(wdata),
        .cfg_ack_in(ack), .cfg_rdata_in(rdata)
    );

    // 100 MHz clock
    initial
    begin
        forever #5 clk = ~clk;
    end

    // ---------------------------------------------------------------
    // Compare and bus helpers
    // ---------------------------------------------------------------
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
            n_errors++;
        end
    endtask : chk

    task automatic rd(input logic [7:0] rn, input logic [31:0] exp);
        logic        a;
        logic [31:0] d;
        host.xfer(1'b0, rn, 32'h0, a, d);
        chk(32'h1, {31'h0, a});
        chk(exp, d);
    endtask : rd

    // Every write is answered, refused or not
    task automatic wr(input logic [7:0] rn, input logic [31:0] wd);
        logic        a;
        logic [31:0] d;
        host.xfer(1'b1, rn, wd, a, d);
        chk(32'h1, {31'h0, a});
    endtask : wr

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset_values();
        rd(`NCR_REG_IDENT, {8'h00, 8'hA5, REV, VER});
        pins <= 8'h5A;
        rd(`NCR_REG_IDENT, {8'h00, 8'hA5, REV, VER});
        rd(`NCR_REG_SWDESC, 32'h0008_0202);
        rd(`NCR_REG_SWCFG, 32'h0);
        rd(`NCR_REG_NODEID, 32'h0);
        rd(`NCR_REG_SWCLK, 32'h0);
        rd(`NCR_REG_REFCLK, 32'h3);
        rd(`NCR_REG_SCANID, SCAN);
        rd(`NCR_REG_USER, {otp, metal});
        rd(`NCR_REG_DIRLO, 32'h0);
        rd(`NCR_REG_DIRHI, 32'h0);
        rd(`NCR_REG_SPARE, 32'h0);
        rd(8'h02, 32'h0);
        chk(32'h3, {16'h0, refclk});
    endtask : t_reset_values

    task automatic t_all_ones();
        wr(`NCR_REG_NODEID, 32'hFFFF_FFFF);
        rd(`NCR_REG_NODEID, 32'h0000_FFFF);
        wr(`NCR_REG_SWCLK, 32'hFFFF_FFFF);
        rd(`NCR_REG_SWCLK, 32'h0000_FFFF);
        chk(32'hFFFF, {16'h0, swclk});
        wr(`NCR_REG_REFCLK, 32'hFFFF_FFFF);
        rd(`NCR_REG_REFCLK, 32'h0000_FFFF);
        wr(`NCR_REG_SPARE, 32'hFFFF_FFFF);
        rd(`NCR_REG_SPARE, 32'h0000_0003);
        chk(32'h3, {30'h0, spare});
        wr(`NCR_REG_SWDESC, 32'h0);
        rd(`NCR_REG_SWDESC, 32'h0008_0202);
        wr(8'h02, 32'hFFFF_FFFF);
        rd(8'h02, 32'h0);
        wr(`NCR_REG_PLL, 32'hFFFF_FFFF);
        chk(32'h0, {30'h0, trst, relock});
        rd(`NCR_REG_PLL, 32'hF39F_FF7F);
        chk(32'h3, {30'h0, byp, jtag});
        chk({3'h7, 13'h1FFF, 7'h7F}, {pdiv, mult, idiv});
    endtask : t_all_ones

    // PLL writes with no control bits, with bit 30 and small field moves, then with bits 31 and 28
    task automatic t_pll_effects();
        wr(`NCR_REG_PLL, 32'h0);
        chk(32'h3, {30'h0, trst, relock});
        chk(32'h0, {30'h0, byp, jtag});
        @(posedge clk);
        #1;
        chk(32'h0, {30'h0, trst, relock});
        wr(`NCR_REG_PLL, 32'h4000_0000 | (32'h5 << 23) | 32'hF90F);
        chk(32'h2, {30'h0, trst, relock});
        chk({3'h5, 13'h00F9, 7'h0F}, {pdiv, mult, idiv});
        wr(`NCR_REG_PLL, 32'h9000_0000);
        chk(32'h1, {30'h0, trst, relock});
        chk(32'h1, {31'h0, jtag});
        chk(32'h0, {pdiv, mult, idiv});
    endtask : t_pll_effects

    task automatic t_header();
        wr(`NCR_REG_SWCFG, 32'h7FFF_FEFF);
        rd(`NCR_REG_SWCFG, 32'h1);
        chk(32'h1, {31'h0, hdr1});
        wr(`NCR_REG_SWCFG, 32'h0);
        chk(32'h0, {31'h0, hdr1});
    endtask : t_header

    task automatic t_route();
        logic [15:0] m;
        wr(`NCR_REG_NODEID, 32'h0000_B3C6);
        chk(32'hB3C6, {16'h0, nid});
        wr(`NCR_REG_DIRLO, 32'h7654_3210);
        wr(`NCR_REG_DIRHI, 32'hFEDC_BA98);
        for (int k = 16; k >= 0; k--)
        begin
            m = (k == 16) ? 16'h0 : ((16'h1 << k) | ((16'h1 << k) - 1));
            @(posedge clk);
            rreq <= 1'b1;
            dest <= 16'hB3C6 ^ m;
            @(posedge clk);
            rreq <= 1'b0;
            #1;
            chk(32'h1, {31'h0, rvalid});
            chk((k == 16) ? 32'h1 : 32'h0, {31'h0, rlocal});
            if (k < 16)
                chk(k, {28'h0, rdir});
        end
    endtask : t_route

    task automatic t_locks();
        wr(`NCR_REG_SWCFG, 32'h0000_0100);
        wr(`NCR_REG_PLL, 32'h0000_0101);
        chk(32'h0, {31'h0, trst});
        rd(`NCR_REG_PLL, 32'h9000_0000);
        wr(`NCR_REG_NODEID, 32'h0000_1234);
        rd(`NCR_REG_NODEID, 32'h0000_1234);
        wr(`NCR_REG_SWCFG, 32'h8000_0000);
        wr(`NCR_REG_NODEID, 32'h0000_0042);
        rd(`NCR_REG_NODEID, 32'h0000_1234);
        wr(`NCR_REG_SWCFG, 32'h0);
        rd(`NCR_REG_SWCFG, 32'h8000_0000);
        wr(`NCR_REG_DIRLO, 32'h0);
        rd(`NCR_REG_DIRLO, 32'h7654_3210);
    endtask : t_locks

    task automatic complete_run();
        $display("errors=%0d compares=%0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    // Main sequence: reset, then each scenario in turn
    initial
    begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        repeat (8) @(posedge clk);
        t_reset_values();
        t_all_ones();
        t_pll_effects();
        t_header();
        t_route();
        t_locks();
        complete_run();
    end

    // Watchdog well past the fewer than 200 cycles the run needs
    initial
    begin
        #100us;
        n_errors++;
        complete_run();
    end
endmodule : node_config_register_bank_bench
`default_nettype wire
